//--- design/dcd_cfg.svh
// constants for the dcd sync sram port
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
`define DCD_ADDR_W        19
`define DCD_DATA_W        36
`define DCD_DATA_W_NARROW 18
`define DCD_LANES         4
`define DCD_LANE_W        9
`define DCD_WORDS_WIDE    262144
`define DCD_WORDS_NARROW  524288
`define DCD_FIFO_DEPTH    32
`define DCD_WB_AW         4
`define DCD_REG_CTRL      4'h0
`define DCD_REG_STATUS    4'h4
`define DCD_REG_WCOUNT    4'h8
`define DCD_CTRL_LINEAR   0
`define DCD_CTRL_HOLD     1
`define DCD_CTRL_CLRDROP  2
`define DCD_ST_BURST      0
`define DCD_ST_CNT        1
`define DCD_ST_EMPTY      3
`define DCD_ST_DROP       4
`define DCD_ST_LEVEL      8
`endif

//--- design/dcd_fifo.sv
// posted-write fifo with valid and ready on both sides
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `DCD_FIFO_DEPTH
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [WIDTH-1:0]         inData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [WIDTH-1:0]              outData,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
    $error("fifo depth must be a power of two");

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtrQ;
  logic [PW:0]      rdPtrQ;
  logic             push;
  logic             pop;

  assign level    = wrPtrQ - rdPtrQ;
  assign inReady  = level != (PW+1)'(DEPTH);
  assign outValid = wrPtrQ != rdPtrQ;
  assign outData  = store[rdPtrQ[PW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
    end
    else
    begin
      if (push)
        wrPtrQ <= wrPtrQ + 1'h1;
      if (pop)
        rdPtrQ <= rdPtrQ + 1'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      store[wrPtrQ[PW-1:0]] <= inData;
  end
endmodule : dcd_fifo

//--- design/dcd_pkg.sv
// shared types for the dcd sync sram port
`include "dcd_cfg.svh"
package dcd_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'h1,
    ST_BURST = 2'h2
  } dcd_burst_t;

  typedef struct packed {
    logic [`DCD_ADDR_W-1:0] addr;
    logic [`DCD_DATA_W-1:0] data;
    logic                   strobePN;
    logic                   strobeCN;
    logic                   advN;
    logic                   selN;
    logic                   selHi;
    logic                   selLoN;
    logic [`DCD_LANES-1:0]  bwN;
    logic                   bweN;
    logic                   gwN;
  } dcd_pins_t;

  typedef struct packed {
    logic [`DCD_ADDR_W-1:0] addr;
    logic [`DCD_DATA_W-1:0] data;
    logic [`DCD_LANES-1:0]  mask;
  } dcd_wr_t;

  // pins as seen with the bus idle
  localparam dcd_pins_t PINS_IDLE = '{addr: '0, data: '0, strobePN: 1'h1, strobeCN: 1'h1,
    advN: 1'h1, selN: 1'h1, selHi: 1'h0, selLoN: 1'h1, bwN: '1, bweN: 1'h1, gwN: 1'h1};
endpackage : dcd_pkg

//--- design/dcd_sram_port.sv
// pipelined double-cycle-deselect sync sram port with wishbone control
`timescale 1ns/1ps
`include "dcd_cfg.svh"
// Functional notes
// - every synchronous pin is caught in a register on the rising clock edge.
// - address and chip enables load only on an edge where one of the two address strobes is low.
// - later burst addresses come from a two-bit counter that steps only while advance is low.
// - the burst counter runs in interleaved or linear order as the user selects.
// - a write is captured in registers and finished into the array without further bus action while the hold control bit is clear.
// - byte lane write controls pick which of up to four lanes a write changes.
// - a low global write writes every lane whatever the lane controls say.
// - after a deselect the data drivers stay on for one extra clock before turning off.
// - output enable and sleep request act without a clock and gate the drivers directly.
// - inputs and outputs are registered so read data leaves two stages after address capture.
// - a burst reads 3-1-1-1: first word three clocks after start, then one per clock.
// - the array holds 262,144 words of 36 bits or 524,288 words of 18 bits.
module dcd_sram_port #(
  parameter int DATA_W     = `DCD_DATA_W,
  parameter int WORDS      = `DCD_WORDS_WIDE,
  parameter int FIFO_DEPTH = `DCD_FIFO_DEPTH
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [`DCD_ADDR_W-1:0] addrIn,
  input  wire logic [DATA_W-1:0]     dqIn,
  output logic [DATA_W-1:0]          dqOut,
  output logic                       dqOe,
  input  wire logic                  processorAddrStrobeN,
  input  wire logic                  controllerAddrStrobeN,
  input  wire logic                  burstAdvanceN,
  input  wire logic                  pipelinedSelectN,
  input  wire logic                  depthSelectHigh,
  input  wire logic                  depthSelectLowN,
  input  wire logic [`DCD_LANES-1:0] byteLaneWriteN,
  input  wire logic                  byteWriteGateN,
  input  wire logic                  globalWriteN,
  input  wire logic                  outputEnableN,
  input  wire logic                  sleepRequest,
  output logic                       wrAccept,
  input  wire logic                  wbCyc,
  input  wire logic                  wbStb,
  input  wire logic                  wbWe,
  input  wire logic [`DCD_WB_AW-1:0] wbAdr,
  input  wire logic [3:0]            wbSel,
  input  wire logic [31:0]           wbDatI,
  output logic [31:0]                wbDatO,
  output logic                       wbAck
);
  localparam int LANES = DATA_W / `DCD_LANE_W;
  localparam int AW    = $clog2(WORDS);
  localparam int LW    = $clog2(FIFO_DEPTH) + 1;

  if (!((DATA_W == `DCD_DATA_W && WORDS <= `DCD_WORDS_WIDE) ||
        (DATA_W == `DCD_DATA_W_NARROW && WORDS <= `DCD_WORDS_NARROW)) || WORDS < 4)
    $error("unsupported array shape");

  default clocking cbAst @(posedge mclk);
  endclocking
  default disable iff (rst);

  function automatic logic [`DCD_LANES-1:0] laneMask(input dcd_pkg::dcd_pins_t p);
    if (!p.gwN)
      laneMask = '1;
    else if (!p.bweN)
      laneMask = ~p.bwN;
    else
      laneMask = '0;
  endfunction : laneMask

  function automatic logic [DATA_W-1:0] mergeLanes(input logic [DATA_W-1:0] oldW,
                                                   input logic [DATA_W-1:0] newW,
                                                   input logic [`DCD_LANES-1:0] m);
    mergeLanes = oldW;
    for (int i = 0; i < LANES; i++)
      if (m[i])
        mergeLanes[i*`DCD_LANE_W +: `DCD_LANE_W] = newW[i*`DCD_LANE_W +: `DCD_LANE_W];
  endfunction : mergeLanes

  function automatic logic [1:0] burstLow(input logic [1:0] base,
                                          input logic [1:0] cnt,
                                          input logic       linear);
    burstLow = linear ? 2'(base + cnt) : (base ^ cnt);
  endfunction : burstLow

  dcd_pkg::dcd_pins_t  pinsQ;
  dcd_pkg::dcd_burst_t burstQ;
  logic [AW-1:0]       baseQ;
  logic [1:0]          cntQ;
  logic [1:0]          cntD;
  logic                startReq;
  logic                selected;
  logic                advance;
  logic                accessEn;
  logic                writeCyc;
  logic [`DCD_LANES-1:0] wrMask;
  logic [AW-1:0]       accAddr;
  logic [DATA_W-1:0]   mem [WORDS];
  logic                rdValidQ;
  logic [DATA_W-1:0]   rdDataQ;
  logic                dataValidQ;
  logic                dqDriveQ;
  logic [DATA_W-1:0]   dqOutQ;
  dcd_pkg::dcd_wr_t    pushWord;
  dcd_pkg::dcd_wr_t    drainWord;
  logic                pushReady;
  logic                drainValid;
  logic                drainEn;
  logic                bypass;
  logic [LW-1:0]       fifoLevel;
  logic                wrAcceptQ;
  logic                linearQ;
  logic                holdQ;
  logic                dropQ;
  logic [31:0]         wrCountQ;
  logic                ackQ;
  logic [31:0]         wbDatQ;
  logic                wbReq;
  logic                wbWrite;
  logic [31:0]         statusWord;

  // input register stage
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pinsQ <= dcd_pkg::PINS_IDLE;
    else
    begin
      pinsQ.addr     <= addrIn;
      pinsQ.data     <= `DCD_DATA_W'(dqIn);
      pinsQ.strobePN <= processorAddrStrobeN;
      pinsQ.strobeCN <= controllerAddrStrobeN;
      pinsQ.advN     <= burstAdvanceN;
      pinsQ.selN     <= pipelinedSelectN;
      pinsQ.selHi    <= depthSelectHigh;
      pinsQ.selLoN   <= depthSelectLowN;
      pinsQ.bwN      <= byteLaneWriteN;
      pinsQ.bweN     <= byteWriteGateN;
      pinsQ.gwN      <= globalWriteN;
    end
  end

  assign startReq = !pinsQ.strobePN || !pinsQ.strobeCN;
  assign selected = !pinsQ.selN && pinsQ.selHi && !pinsQ.selLoN;
  assign advance  = burstQ == dcd_pkg::ST_BURST && !startReq && !pinsQ.advN;
  assign accessEn = !sleepRequest && (startReq ? selected : burstQ == dcd_pkg::ST_BURST);
  assign cntD     = startReq ? 2'h0 : (advance ? 2'(cntQ + 2'h1) : cntQ);
  assign accAddr  = startReq ? pinsQ.addr[AW-1:0] : {baseQ[AW-1:2], burstLow(baseQ[1:0], cntD, linearQ)};
  assign wrMask   = laneMask(pinsQ);
  assign writeCyc = accessEn && (|wrMask[LANES-1:0]);

  // burst address generator
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      burstQ <= dcd_pkg::ST_IDLE;
      baseQ  <= '0;
      cntQ   <= 2'h0;
    end
    else if (!sleepRequest)
    begin
      case (burstQ)
        dcd_pkg::ST_IDLE, dcd_pkg::ST_BURST:
        begin
          if (startReq)
          begin
            burstQ <= selected ? dcd_pkg::ST_BURST : dcd_pkg::ST_IDLE;
            if (selected)
              baseQ <= pinsQ.addr[AW-1:0];
            cntQ <= 2'h0;
          end
          else if (advance)
            cntQ <= 2'(cntQ + 2'h1);
        end
        default:
          burstQ <= dcd_pkg::ST_IDLE;
      endcase
    end
  end

  // array read stage, forwarding a write that lands in the same edge
  assign bypass = drainEn && drainWord.addr[AW-1:0] == accAddr;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdValidQ <= 1'h0;
    else
      rdValidQ <= accessEn && !writeCyc;
  end

  always_ff @(posedge mclk)
  begin
    if (bypass)
      rdDataQ <= mergeLanes(mem[accAddr], drainWord.data[DATA_W-1:0], drainWord.mask);
    else
      rdDataQ <= mem[accAddr];
  end

  // output register stage with the extra enable register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dataValidQ <= 1'h0;
      dqDriveQ   <= 1'h0;
      dqOutQ     <= '0;
    end
    else
    begin
      dataValidQ <= rdValidQ;
      dqDriveQ   <= rdValidQ || dataValidQ;
      if (rdValidQ)
        dqOutQ <= rdDataQ;
    end
  end

  assign dqOut = dqOutQ;
  assign dqOe  = dqDriveQ && !outputEnableN && !sleepRequest;

  // posted writes drain into the array on their own while holdQ is clear
  assign pushWord.addr = `DCD_ADDR_W'(accAddr);
  assign pushWord.data = pinsQ.data;
  assign pushWord.mask = wrMask;
  assign drainEn       = drainValid && !holdQ;

  dcd_fifo #(
    .WIDTH ($bits(dcd_pkg::dcd_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) uWrFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (writeCyc),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (drainValid),
    .outReady (!holdQ),
    .outData  (drainWord),
    .level    (fifoLevel)
  );

  always_ff @(posedge mclk)
  begin
    if (drainEn)
      mem[drainWord.addr[AW-1:0]] <= mergeLanes(mem[drainWord.addr[AW-1:0]],
                                                drainWord.data[DATA_W-1:0], drainWord.mask);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrAcceptQ <= 1'h1;
      wrCountQ  <= 32'h0000_0000;
    end
    else
    begin
      wrAcceptQ <= fifoLevel < LW'(FIFO_DEPTH - 1);
      if (drainEn)
        wrCountQ <= wrCountQ + 32'h0000_0001;
    end
  end

  assign wrAccept = wrAcceptQ;

  // wishbone register slave
  assign wbReq   = wbCyc && wbStb;
  assign wbWrite = wbReq && wbWe && ackQ && wbSel[0] && wbAdr == `DCD_REG_CTRL;

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[`DCD_ST_BURST] = burstQ == dcd_pkg::ST_BURST;
    statusWord[`DCD_ST_CNT +: 2] = cntQ;
    statusWord[`DCD_ST_EMPTY] = !drainValid;
    statusWord[`DCD_ST_DROP] = dropQ;
    statusWord[`DCD_ST_LEVEL +: LW] = fifoLevel;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ackQ   <= 1'h0;
      wbDatQ <= 32'h0000_0000;
    end
    else
    begin
      ackQ <= wbReq && !ackQ;
      if (wbReq && !ackQ)
      begin
        case (wbAdr)
          `DCD_REG_CTRL:
            wbDatQ <= {29'h0000_0000, 1'h0, holdQ, linearQ};
          `DCD_REG_STATUS:
            wbDatQ <= statusWord;
          `DCD_REG_WCOUNT:
            wbDatQ <= wrCountQ;
          default:
            wbDatQ <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      linearQ <= 1'h0;
      holdQ   <= 1'h0;
    end
    else if (wbWrite)
    begin
      linearQ <= wbDatI[`DCD_CTRL_LINEAR];
      holdQ   <= wbDatI[`DCD_CTRL_HOLD];
    end
  end

  // lost write is sticky, a new loss beats the clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dropQ <= 1'h0;
    else if (writeCyc && !pushReady)
      dropQ <= 1'h1;
    else if (wbWrite && wbDatI[`DCD_CTRL_CLRDROP])
      dropQ <= 1'h0;
  end

  assign wbAck  = ackQ;
  assign wbDatO = wbDatQ;

  AST_CAPTURE: assert property (pinsQ.gwN == $past(globalWriteN) && pinsQ.addr == $past(addrIn))
    else $error("pins not registered");
  AST_LOAD_ON_STROBE: assert property (!startReq |=> $stable(baseQ))
    else $error("base moved without strobe");
  AST_COUNT_HOLD: assert property (!startReq && pinsQ.advN && !sleepRequest |=> $stable(cntQ))
    else $error("counter stepped without advance");
  AST_LINEAR_STEP: assert property (linearQ && advance && !sleepRequest && cntQ == 2'h0 |->
    accAddr[1:0] == 2'(baseQ[1:0] + 2'h1))
    else $error("linear order wrong");
  AST_POST_DRAIN: assert property (writeCyc && !drainValid && !holdQ |=> drainEn)
    else $error("posted write not drained");
  AST_NO_LANE: assert property (pinsQ.gwN && pinsQ.bweN |-> !writeCyc)
    else $error("write without lane control");
  AST_GLOBAL_ALL: assert property (!pinsQ.gwN |-> wrMask == '1)
    else $error("global write missed a lane");
  AST_DESELECT_HOLD: assert property ($fell(dataValidQ) |-> dqDriveQ ##1 (!dqDriveQ || dataValidQ))
    else $error("driver not kept one extra cycle");
  AST_OE_GATE: assert property (outputEnableN || sleepRequest |-> !dqOe)
    else $error("drivers on while disabled");
  AST_PIPE_DATA: assert property (rdValidQ |=> dataValidQ && dqOutQ == $past(rdDataQ))
    else $error("output stage lost read data");
  AST_FIRST_WORD: assert property (!processorAddrStrobeN && !pipelinedSelectN && depthSelectHigh &&
    !depthSelectLowN && globalWriteN && byteWriteGateN && !sleepRequest ##1 !sleepRequest
    |-> ##2 dataValidQ)
    else $error("first word not on third clock");
endmodule : dcd_sram_port

//--- verif/dcd_ctrl_model.sv
// controller-side model that drives the sram pins
`timescale 1ns/1ps
module dcd_ctrl_model (
  input  wire logic          mclk,
  input  wire logic [35:0]   dqOut,
  input  wire logic          dqOe,
  output dcd_pkg::dcd_pins_t pins
);
  dcd_pkg::dcd_pins_t p;

  initial pins = dcd_pkg::PINS_IDLE;

  // selected part at an address, released data lines show inverted
  function automatic dcd_pkg::dcd_pins_t sel(input logic [18:0] a);
    sel = dcd_pkg::PINS_IDLE;
    sel.data = ~pins.data;
    sel.addr = a;
    sel.selN = 1'h0;
    sel.selHi = 1'h1;
    sel.selLoN = 1'h0;
  endfunction : sel

  task automatic wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] bwN, input logic gwN);
    p = sel(a);
    p.strobeCN = 1'h0;
    p.data = d;
    p.bwN = bwN;
    p.bweN = &bwN;
    p.gwN = gwN;
    pins <= p;
    @(posedge mclk);
  endtask : wr

  // strobe with select off ends any running burst first
  task automatic idle(input int n);
    p = dcd_pkg::PINS_IDLE;
    p.data = ~pins.data;
    p.strobeCN = 1'h0;
    pins <= p;
    @(posedge mclk);
    p.strobeCN = 1'h1;
    pins <= p;
    repeat (n) @(posedge mclk);
  endtask : idle

  // burst of four, then a deselect; words and driver enable seen per cycle
  task automatic rd(input logic [18:0] a, output logic [35:0] w [4], output logic [7:0] oe);
    p = sel(a);
    p.strobePN = 1'h0;
    pins <= p;
    for (int j = 0; j < 8; j++)
    begin
      @(posedge mclk);
      p.strobePN = 1'h1;
      p.strobeCN = (j == 3) ? 1'h0 : 1'h1;
      p.advN = (j < 3) ? 1'h0 : 1'h1;
      p.selN = (j < 3) ? 1'h0 : 1'h1;
      p.data = ~p.data;
      pins <= p;
      @(negedge mclk);
      if (j >= 2 && j <= 5)
        w[j-2] = dqOut;
      oe[j] = dqOe;
    end
    @(posedge mclk);
  endtask : rd
endmodule : dcd_ctrl_model

//--- verif/tb_pipelined_dcd_sync_sram_port.sv
// testbench for the pipelined dcd sync sram port
`timescale 1ns/1ps
module tb_pipelined_dcd_sync_sram_port;
  localparam int FD = 32;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic               outputEnableN = 1'b0;
  logic               sleepRequest = 1'b0;
  logic               wbCyc = 1'b0;
  logic               wbStb = 1'b0;
  logic               wbWe = 1'b0;
  logic [3:0]         wbAdr = 4'h0;
  logic [31:0]        wbDatI = 32'h0000_0000;
  logic [31:0]        wbDatO;
  logic               wbAck;
  logic [35:0]        dqOut;
  logic               dqOe;
  logic               wrAccept;
  dcd_pkg::dcd_pins_t pins;
  logic [31:0]        seed = 32'h90de_71b8;
  logic [35:0]        mem [16];
  int                 errors = 0;
  int                 checked = 0;

  always #25 mclk = ~mclk;

  dcd_ctrl_model i_ctl (.mclk(mclk), .dqOut(dqOut), .dqOe(dqOe), .pins(pins));

  dcd_sram_port #(.DATA_W(36), .WORDS(64), .FIFO_DEPTH(FD)) i_dut (
    .mclk(mclk), .rst(rst), .addrIn(pins.addr), .dqIn(pins.data), .dqOut(dqOut), .dqOe(dqOe),
    .processorAddrStrobeN(pins.strobePN), .controllerAddrStrobeN(pins.strobeCN),
    .burstAdvanceN(pins.advN), .pipelinedSelectN(pins.selN), .depthSelectHigh(pins.selHi),
    .depthSelectLowN(pins.selLoN), .byteLaneWriteN(pins.bwN), .byteWriteGateN(pins.bweN),
    .globalWriteN(pins.gwN), .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
    .wrAccept(wrAccept), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // lanes of nine bits; global write takes every lane
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] bwN,
                                        input logic gwN);
    merge = o;
    for (int l = 0; l < 4; l++)
      if (!gwN || !bwN[l])
        merge[l*9 +: 9] = n[l*9 +: 9];
  endfunction : merge

  function automatic logic [3:0] baddr(input logic [3:0] a, input int k, input logic lin);
    return lin ? {a[3:2], a[1:0] + 2'(k)} : {a[3:2], a[1:0] ^ 2'(k)};
  endfunction : baddr

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
    chk(36'(n < 20), 36'h1);
  endtask : wb

  // burst read with driver enable pulled by oe (k%3==1) or sleep (k%3==2)
  task automatic rdchk(input int k);
    logic [31:0] r;
    logic [35:0] w [4];
    logic [7:0]  oe;
    logic [3:0]  b;
    wb(1'b1, 4'h0, (k >= 3) ? 32'h0000_0001 : 32'h0000_0000, r);
    b = 4'(rnd());
    fork
      i_ctl.rd({15'h0, b}, w, oe);
      begin
        if (k % 3 == 1)
        begin
          repeat (5) @(posedge mclk);
          outputEnableN <= 1'b1;
          @(posedge mclk);
          outputEnableN <= 1'b0;
        end
        if (k % 3 == 2)
        begin
          repeat (7) @(posedge mclk);
          sleepRequest <= 1'b1;
          @(posedge mclk);
          sleepRequest <= 1'b0;
        end
      end
    join
    for (int i = 0; i < 4; i++)
      chk(w[i], mem[baddr(b, i, k >= 3)]);
    chk(36'(oe), (k % 3 == 0) ? 36'h7c : (k % 3 == 1) ? 36'h6c : 36'h3c);
  endtask : rdchk

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test();
  end

  initial
  begin
    logic [31:0] r;
    logic [35:0] d;
    logic [3:0]  m;
    logic        g;
    int          nw;
    int          done;
    nw = 0;
    done = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    wb(1'b0, 4'hc, 32'h0000_0000, r);
    chk(36'(r), 36'h0);
    wb(1'b0, 4'h4, 32'h0000_0000, r);
    chk(36'(r[3]), 36'h1);
    for (int i = 0; i < 48; i++)
    begin
      d = 36'({rnd(), rnd()});
      m = (i < 16) ? 4'hf : d[7:4];
      g = (i < 16) ? 1'b0 : d[8];
      if (i < 16)
        d[3:0] = 4'(i);
      i_ctl.wr({15'h0, d[3:0]}, d, m, g);
      mem[d[3:0]] = merge(mem[d[3:0]], d, m, g);
      nw += (!g || m != 4'hf) ? 1 : 0;
    end
    i_ctl.idle(4);
    for (int k = 0; k < 6; k++)
      rdchk(k);
    wb(1'b1, 4'h0, 32'h0000_0002, r);
    for (int i = 0; i < 40 && done < 3; i++)
    begin
      d = 36'({rnd(), rnd()});
      i_ctl.wr({15'h0, d[3:0]}, d, 4'hf, 1'b0);
      if (i < FD)
        mem[d[3:0]] = d;
      if (wrAccept !== 1'b1)
        done++;
    end
    i_ctl.idle(2);
    chk(36'(done), 36'h3);
    wb(1'b0, 4'h4, 32'h0000_0000, r);
    chk(36'({r[13:8], r[4:3]}), {28'h0, 6'(FD), 2'b10});
    wb(1'b1, 4'h0, 32'h0000_0004, r);
    done = 0;
    do
    begin
      wb(1'b0, 4'h4, 32'h0000_0000, r);
      done++;
    end
    while (r[3] !== 1'b1 && done < 20);
    chk(36'({r[4], r[3]}), 36'h1);
    wb(1'b0, 4'h8, 32'h0000_0000, r);
    chk(36'(r), 36'(nw + FD));
    for (int k = 0; k < 3; k++)
      rdchk(k * 2);
    stop_test();
  end
endmodule : tb_pipelined_dcd_sync_sram_port
